//--- design/wit_params.svh
// Purpose: Constants for the two-channel watchdog and interval timer.
// Assumes: Included by the package and by the timer module.
// Notes: Addresses are the byte addresses seen on the internal bus.
`ifndef WIT_PARAMS_SVH
`define WIT_PARAMS_SVH
`define WIT_WADDR_CH0 16'hffa8
`define WIT_RADDR_CSR_CH0 16'hffa8
`define WIT_RADDR_CNT_CH0 16'hffa9
`define WIT_WADDR_CH1 16'hffea
`define WIT_RADDR_CSR_CH1 16'hffea
`define WIT_RADDR_CNT_CH1 16'hffeb
`define WIT_KEY_CNT 8'h5a
`define WIT_KEY_CSR 8'ha5
`define WIT_BIT_OVF 7
`define WIT_BIT_MODE 6
`define WIT_BIT_TME 5
`define WIT_BIT_PSS 4
`define WIT_BIT_RST 3
`define WIT_CSR_RESET 8'h00
`define WIT_CNT_RESET 8'h00
`define WIT_CNT_MAX 8'hff
`define WIT_RST_CYCLES 518
`define WIT_RST_CW 10
`define WIT_MAIN_PW 15
`define WIT_SUB_PW 8
`endif

//--- design/wit_pkg.sv
// Purpose: Types shared by the watchdog and interval timer.
// Assumes: Constants come from the parameter header.
// Notes: The whole timer state is one packed struct.
`include "wit_params.svh"
package wit_pkg;
   typedef struct packed {
      logic [1:0][7:0] cnt;
      logic [1:0][7:0] ctl;
      logic [1:0] armed;
      logic [1:0] ptap;
      logic [1:0][`WIT_RST_CW-1:0] rcnt;
      logic [1:0] nmi;
      logic [7:0] rdata;
      logic [`WIT_MAIN_PW-1:0] pre;
      logic [`WIT_SUB_PW-1:0] sub;
      logic sub_prev;
   } wit_state_s;
endpackage

//--- design/wit_timer.sv
// Purpose: Two-channel watchdog and interval timer with keyed register writes.
// Assumes: Bus strobes and the sub-clock input are synchronous to clock.
// Notes: Channel 0 counts main prescaler taps; channel 1 may use the sub-clock.
`include "wit_params.svh"
module wit_timer
   import wit_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic sub_clk,
   input wire logic [15:0] bus_addr,
   input wire logic bus_rd,
   input wire logic bus_wr,
   input wire logic bus_word,
   input wire logic [15:0] bus_wdata,
   output logic [7:0] bus_rdata,
   output logic [1:0] chip_reset_req,
   output logic [1:0] nmi_req,
   output logic [1:0] interval_interrupt
);

   wit_state_s st;
   wit_state_s next_st;
   logic [1:0] tick;
   logic [1:0] wrap;
   logic [1:0] csr_wr;
   logic [1:0] cnt_wr;

   // Shared write address of a channel.
   function automatic logic [15:0] waddr(input int ch);
      return (ch == 1) ? `WIT_WADDR_CH1 : `WIT_WADDR_CH0;
   endfunction

   // Main prescaler tap; codes without a divider give a flat line, so no count.
   function automatic logic main_tap(input logic [`WIT_MAIN_PW-1:0] pre,
                                     input logic [2:0] cks, input logic ch1);
      unique case (cks)
         3'h0: main_tap = pre[0];
         3'h1: main_tap = pre[5];
         3'h2: main_tap = pre[6];
         3'h3: main_tap = pre[8];
         3'h4: main_tap = pre[10];
         3'h5: main_tap = pre[12];
         3'h6: main_tap = ch1 & pre[14];
         3'h7: main_tap = 1'b0;
      endcase
   endfunction

   // Next-state logic for prescalers, both channels and the read port.
   always_comb begin
      logic tap;
      logic clr;
      logic rd_csr;
      tap = 1'b0;
      clr = 1'b0;
      rd_csr = 1'b0;
      next_st = st;
      tick = 2'b00;
      wrap = 2'b00;
      csr_wr = 2'b00;
      cnt_wr = 2'b00;
      // Prescalers never stop, so a channel's phase is independent of its enable.
      next_st.pre = st.pre + `WIT_MAIN_PW'(1);
      next_st.sub_prev = sub_clk;
      if (st.sub_prev && !sub_clk) begin
         next_st.sub = st.sub + `WIT_SUB_PW'(1);
      end
      // Reads of unmapped addresses return zero.
      if (bus_rd) begin
         unique case (bus_addr)
            `WIT_RADDR_CSR_CH0: next_st.rdata = st.ctl[0];
            `WIT_RADDR_CNT_CH0: next_st.rdata = st.cnt[0];
            `WIT_RADDR_CSR_CH1: next_st.rdata = st.ctl[1];
            `WIT_RADDR_CNT_CH1: next_st.rdata = st.cnt[1];
            default: next_st.rdata = 8'h00;
         endcase
      end
      for (int ch = 0; ch < 2; ch++) begin
         // Only a word write carrying the right key reaches a register.
         csr_wr[ch] = bus_wr && bus_word && (bus_addr == waddr(ch))
                      && (bus_wdata[15:8] == `WIT_KEY_CSR);
         cnt_wr[ch] = bus_wr && bus_word && (bus_addr == waddr(ch))
                      && (bus_wdata[15:8] == `WIT_KEY_CNT);
         rd_csr = bus_rd && (bus_addr == ((ch == 1) ? `WIT_RADDR_CSR_CH1
                                                    : `WIT_RADDR_CSR_CH0));
         // Tap choice; a change of code can look like a falling edge.
         if (ch == 1 && st.ctl[1][`WIT_BIT_PSS]) begin
            tap = st.sub[st.ctl[1][2:0]];
         end else begin
            tap = main_tap(st.pre, st.ctl[ch][2:0], ch == 1);
         end
         next_st.ptap[ch] = tap;
         tick[ch] = st.ptap[ch] && !tap;
         // A keyed counter write wins over a tick in the same cycle.
         wrap[ch] = st.ctl[ch][`WIT_BIT_TME] && tick[ch] && !cnt_wr[ch]
                    && (st.cnt[ch] == `WIT_CNT_MAX);
         if (csr_wr[ch]) begin
            next_st.ctl[ch][6:0] = bus_wdata[6:0];
            if (ch == 0) begin
               next_st.ctl[0][`WIT_BIT_PSS] = 1'b0;
            end
         end
         // Flag clears: keyed zero after an armed read, enable off, reset pulse.
         clr = (csr_wr[ch] && !bus_wdata[`WIT_BIT_TME])
               || (csr_wr[ch] && !bus_wdata[`WIT_BIT_OVF] && st.armed[ch])
               || (st.rcnt[ch] != '0);
         // A new overflow wins over any clear in the same cycle.
         next_st.ctl[ch][`WIT_BIT_OVF] = wrap[ch]
                                         || (st.ctl[ch][`WIT_BIT_OVF] && !clr);
         next_st.armed[ch] = next_st.ctl[ch][`WIT_BIT_OVF]
                             && (st.armed[ch] || (rd_csr && st.ctl[ch][`WIT_BIT_OVF]));
         // Counter is held at zero while disabled; writes then have no effect.
         if (!next_st.ctl[ch][`WIT_BIT_TME]) begin
            next_st.cnt[ch] = `WIT_CNT_RESET;
         end else if (cnt_wr[ch]) begin
            next_st.cnt[ch] = bus_wdata[7:0];
         end else if (tick[ch] && st.ctl[ch][`WIT_BIT_TME]) begin
            next_st.cnt[ch] = st.cnt[ch] + 8'h01;
         end
         // Overflow action in watchdog mode picks reset or NMI.
         next_st.nmi[ch] = wrap[ch] && st.ctl[ch][`WIT_BIT_MODE]
                           && !st.ctl[ch][`WIT_BIT_RST];
         if (wrap[ch] && st.ctl[ch][`WIT_BIT_MODE] && st.ctl[ch][`WIT_BIT_RST]) begin
            next_st.rcnt[ch] = `WIT_RST_CW'(`WIT_RST_CYCLES);
         end else if (st.rcnt[ch] != '0) begin
            next_st.rcnt[ch] = st.rcnt[ch] - `WIT_RST_CW'(1);
         end
      end
   end

   // State register; the internal reset request does not reset this block.
   always_ff @(posedge clock) begin
      if (!rstn) begin
         next_st_reset: begin
            st.cnt <= {2{`WIT_CNT_RESET}};
            st.ctl <= {2{`WIT_CSR_RESET}};
            st.armed <= 2'h0;
            st.ptap <= 2'h0;
            st.rcnt <= '0;
            st.nmi <= 2'h0;
            st.rdata <= 8'h00;
            st.pre <= '0;
            st.sub <= '0;
            st.sub_prev <= 1'b0;
         end
      end else begin
         st <= next_st;
      end
   end

   // Outputs; in interval mode the interval request follows the flag directly.
   assign bus_rdata = st.rdata;
   assign nmi_req = st.nmi;
   always_comb begin
      for (int ch = 0; ch < 2; ch++) begin
         chip_reset_req[ch] = st.rcnt[ch] != '0;
         interval_interrupt[ch] = st.ctl[ch][`WIT_BIT_OVF]
                                  && !st.ctl[ch][`WIT_BIT_MODE];
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   // A disabled channel always shows a zero count.
   AST_CNT_ZERO_WHILE_OFF: assert property (
      !st.ctl[1][`WIT_BIT_TME] |-> st.cnt[1] == 8'h00)
      else $error("Counter not zero while disabled.");

   // An unobstructed tick advances the count by exactly one.
   AST_CNT_STEP: assert property (
      st.ctl[0][`WIT_BIT_TME] && tick[0] && !cnt_wr[0] && !csr_wr[0]
      |=> st.cnt[0] == $past(st.cnt[0]) + 8'h01)
      else $error("Counter did not step by one on a tick.");

   // Wrap from the top value raises the flag with a zero count.
   AST_OVF_ON_WRAP: assert property (
      wrap[1] |=> st.ctl[1][`WIT_BIT_OVF] && st.cnt[1] == 8'h00)
      else $error("Flag not set on counter wrap.");

   // Writing one to a clear flag leaves it clear.
   AST_OVF_NO_SET_BY_WRITE: assert property (
      csr_wr[0] && bus_wdata[`WIT_BIT_OVF] && !st.ctl[0][`WIT_BIT_OVF] && !wrap[0]
      |=> !st.ctl[0][`WIT_BIT_OVF])
      else $error("Flag was set by a write.");

   // A zero write without the prior read does not clear the flag.
   AST_OVF_NEEDS_READ: assert property (
      csr_wr[0] && !bus_wdata[`WIT_BIT_OVF] && bus_wdata[`WIT_BIT_TME]
      && st.ctl[0][`WIT_BIT_OVF] && !st.armed[0] && st.rcnt[0] == '0
      |=> st.ctl[0][`WIT_BIT_OVF])
      else $error("Flag cleared without a prior read.");

   // The internal reset lasts exactly its cycle count; channel 1 is the one driven into it.
   AST_RST_LENGTH: assert property (
      $rose(chip_reset_req[1]) |-> ##[517:517] chip_reset_req[1] ##1 !chip_reset_req[1])
      else $error("Internal reset length wrong.");

   // Internal reset removes the flag one cycle after it starts.
   AST_RST_CLEARS_OVF: assert property (
      $rose(chip_reset_req[1]) && !wrap[1] |=> !st.ctl[1][`WIT_BIT_OVF])
      else $error("Flag not cleared by internal reset.");

   // In interval mode the request appears in the very cycle the wrap sets the flag.
   AST_IRQ_WITH_FLAG: assert property (
      wrap[0] && !st.ctl[0][`WIT_BIT_MODE] && !csr_wr[0]
      |=> interval_interrupt[0] && st.ctl[0][`WIT_BIT_OVF])
      else $error("Interval request missing when flag set.");

   // Watchdog NMI mode pulses the request after a wrap.
   AST_NMI_PULSE: assert property (
      wrap[0] && st.ctl[0][`WIT_BIT_MODE] && !st.ctl[0][`WIT_BIT_RST]
      |=> nmi_req[0] ##1 !nmi_req[0] || wrap[0])
      else $error("NMI request not a single pulse.");

   // Byte writes never change the control settings.
   AST_BYTE_IGNORED: assert property (
      bus_wr && !bus_word |=> st.ctl[0][6:0] == $past(st.ctl[0][6:0]))
      else $error("Byte write changed control register.");

   // Channel 0 likewise reads zero whenever it is stopped.
   AST_CNT0_ZERO_WHILE_OFF: assert property (
      !st.ctl[0][`WIT_BIT_TME] |-> st.cnt[0] == 8'h00)
      else $error("Channel 0 counter not zero while disabled.");

   // Without a tick or a write the running count must not move.
   AST_CNT_HOLD: assert property (
      st.ctl[0][`WIT_BIT_TME] && !tick[0] && !cnt_wr[0] && !csr_wr[0]
      |=> st.cnt[0] == $past(st.cnt[0]))
      else $error("Counter moved without a tick.");

   // A keyed load while running takes the low byte of the word.
   AST_CNT_LOAD: assert property (
      cnt_wr[1] && st.ctl[1][`WIT_BIT_TME] |=> st.cnt[1] == $past(bus_wdata[7:0]))
      else $error("Keyed counter load lost.");

   // Turning the enable off drops the flag unless an overflow lands at once.
   AST_OVF_CLR_BY_TME: assert property (
      csr_wr[0] && !bus_wdata[`WIT_BIT_TME] && !wrap[0] |=> !st.ctl[0][`WIT_BIT_OVF])
      else $error("Flag survived an enable-off write.");

   // Reading the set flag arms the clearing write.
   AST_ARM_ON_READ: assert property (
      bus_rd && bus_addr == `WIT_RADDR_CSR_CH0 && st.ctl[0][`WIT_BIT_OVF] && !csr_wr[0]
      && st.rcnt[0] == '0 |=> st.armed[0])
      else $error("Read of the set flag did not arm the clear.");

   // An armed zero write removes the flag.
   AST_OVF_CLR_AFTER_READ: assert property (
      csr_wr[0] && !bus_wdata[`WIT_BIT_OVF] && st.armed[0] && !wrap[0]
      |=> !st.ctl[0][`WIT_BIT_OVF])
      else $error("Flag not cleared after read and zero write.");

   // In interval mode an overflow never raises the NMI request.
   AST_INTERVAL_NO_NMI: assert property (
      wrap[0] && !st.ctl[0][`WIT_BIT_MODE] |=> !nmi_req[0])
      else $error("NMI request in interval mode.");

   // Reset selection gives the internal reset and no NMI.
   AST_RST_NOT_NMI: assert property (
      wrap[1] && st.ctl[1][`WIT_BIT_MODE] && st.ctl[1][`WIT_BIT_RST]
      |=> chip_reset_req[1] && !nmi_req[1])
      else $error("Reset selection gave wrong overflow action.");

   // Channel 1 with the NMI choice raises its request after a wrap.
   AST_NMI1_ON_WRAP: assert property (
      wrap[1] && st.ctl[1][`WIT_BIT_MODE] && !st.ctl[1][`WIT_BIT_RST]
      |=> nmi_req[1])
      else $error("Channel 1 NMI request missing after a wrap.");

   // A counter read returns the count sampled with the strobe.
   AST_RDATA_CNT: assert property (
      bus_rd && bus_addr == `WIT_RADDR_CNT_CH1 |=> bus_rdata == $past(st.cnt[1]))
      else $error("Counter read returned a stale value.");

   // The interval request stays up until something clears the flag.
   AST_IRQ_HOLD: assert property (
      interval_interrupt[0] && !csr_wr[0] && st.rcnt[0] == '0 |=> interval_interrupt[0])
      else $error("Interval request dropped while flag set.");

   // Every falling sub-clock edge advances the sub prescaler by one.
   AST_SUB_STEP: assert property (
      st.sub_prev && !sub_clk |=> st.sub == $past(st.sub) + `WIT_SUB_PW'(1))
      else $error("Sub prescaler missed a sub-clock edge.");

endmodule

//--- dv/wit_timer_bench.sv
// Purpose: Self-checking bench for the two-channel watchdog and interval timer.
// Assumes: Every input is driven on the falling edge of clock.
// Notes: Tick periods are measured by reading a counter every cycle.
`include "wit_params.svh"
module wit_timer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 0, rstn = 0, sub_clk = 0, bus_rd = 0, bus_wr = 0, bus_word = 0, pend = 0;
   logic [15:0] bus_addr = 16'h0000, bus_wdata = 16'h0000;
   logic [7:0] bus_rdata, rv;
   logic [1:0] chip_reset_req, nmi_req, interval_interrupt;
   logic [7:0] exp_q[$];
   int fail_count = 0, checked = 0, g, n, sc = 0;
   int dm[6] = '{2, 64, 128, 512, 2048, 8192};

   wit_timer wit_timer_inst (.clock(clock), .rstn(rstn), .sub_clk(sub_clk),
      .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_word(bus_word),
      .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .chip_reset_req(chip_reset_req),
      .nmi_req(nmi_req), .interval_interrupt(interval_interrupt));

   // System clock at 40 MHz.
   initial begin
      forever #12.5 clock = ~clock;
   end

   // Sub-clock period is four system clocks, so its tick gaps are exact.
   always @(negedge clock) begin
      sc <= sc + 1;
      if (sc[0]) sub_clk <= ~sub_clk;
   end

   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: read %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic cmpi(input int got, input int exp);
      checked++;
      if (got != exp) begin
         fail_count++;
         $display("wrong value at %0t: count %0d, expected %0d", $time, got, exp);
      end
   endtask

   task automatic cmp1(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: output %b, expected %b", $time, got, exp);
      end
   endtask

   // Read data lands one cycle after the strobe; polling reads leave the queue empty.
   always @(posedge clock) pend <= bus_rd;
   always @(negedge clock) begin
      if (pend && exp_q.size() > 0) cmp8(bus_rdata, exp_q.pop_front());
   end

   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(negedge clock);
      bus_addr = a;
      bus_rd = 1;
      exp_q.push_back(e);
      @(negedge clock);
      bus_rd = 0;
   endtask

   task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic w = 1);
      @(negedge clock);
      bus_addr = a;
      bus_wdata = d;
      bus_word = w;
      bus_wr = 1;
      @(negedge clock);
      bus_wr = 0;
   endtask

   // Cycles between two increments; the first change only aligns to a tick.
   task automatic gap(input logic [15:0] a, output int t);
      logic [7:0] v;
      @(negedge clock);
      bus_addr = a;
      bus_rd = 1;
      @(negedge clock);
      for (int k = 0; k < 2; k++) begin
         v = bus_rdata;
         t = 0;
         while (bus_rdata === v && t < 20000) begin
            @(negedge clock);
            t++;
         end
      end
      bus_rd = 0;
   endtask

   task automatic test_done;
      $display("checked %0d, fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Main sequence: reset, then one block per behaviour.
   initial begin
      void'($urandom(32'hbc07));
      repeat (20) @(negedge clock);
      rstn = 1;
      wr(16'hffa8, 16'ha520, 1'b0);
      wr(16'hffa8, 16'h5520);
      wr(16'hffaa, 16'ha520);
      rd(16'hffa8, 8'h00);
      rd(16'hffa9, 8'h00);
      rd(16'hffea, 8'h00);
      rd(16'hffeb, 8'h00);
      rd(16'hffaa, 8'h00);
      $display("test reset done");
      // Code 111 on the main prescaler gives no ticks, so loads read back unchanged.
      wr(16'hffea, 16'ha527);
      repeat (4) begin
         rv = 8'($urandom);
         wr(16'hffea, {8'h5a, rv});
         rd(16'hffeb, rv);
      end
      rd(16'hffea, 8'h27);
      $display("test load done");
      // Codes change only while stopped, so no false tick is counted.
      for (int c = 0; c < 6; c++) begin
         wr(16'hffa8, 16'ha500 | 16'(c));
         wr(16'hffa8, 16'ha520 | 16'(c));
         gap(16'hffa9, g);
         cmpi(g, dm[c]);
      end
      for (int c = 0; c < 8; c++) begin
         wr(16'hffea, 16'ha510 | 16'(c));
         wr(16'hffea, 16'ha530 | 16'(c));
         gap(16'hffeb, g);
         cmpi(g, 8 << c);
      end
      $display("test prescaler done");
      wr(16'hffa8, 16'ha520);
      wr(16'hffa8, 16'h5afe);
      n = 0;
      while (interval_interrupt[0] !== 1'b1 && n < 50) begin
         @(negedge clock);
         n++;
      end
      cmp1(interval_interrupt[0], 1'b1);
      rd(16'hffa8, 8'ha0);
      // Bit 7 is written as one here, so only the enable-off path can clear the flag.
      wr(16'hffa8, 16'ha580);
      cmp1(interval_interrupt[0], 1'b0);
      wr(16'hffa8, 16'ha580);
      rd(16'hffa8, 8'h00);
      wr(16'hffa8, 16'h5a55);
      repeat (8) @(negedge clock);
      rd(16'hffa9, 8'h00);
      wr(16'hffa8, 16'ha520);
      rd(16'hffa8, 8'h20);
      $display("test interval done");
      wr(16'hffa8, 16'ha561);
      wr(16'hffa8, 16'h5afe);
      n = 0;
      while (nmi_req[0] !== 1'b1 && n < 300) begin
         @(negedge clock);
         n++;
      end
      cmp1(nmi_req[0], 1'b1);
      @(negedge clock);
      cmp1(nmi_req[0], 1'b0);
      cmp1(chip_reset_req[0] | interval_interrupt[0], 1'b0);
      wr(16'hffa8, 16'ha561);
      rd(16'hffa8, 8'he1);
      wr(16'hffa8, 16'ha5e1);
      rd(16'hffa8, 8'he1);
      wr(16'hffa8, 16'ha561);
      rd(16'hffa8, 8'h61);
      $display("test nmi done");
      wr(16'hffea, 16'ha569);
      wr(16'hffea, 16'h5afe);
      n = 0;
      while (chip_reset_req[1] !== 1'b1 && n < 300) begin
         @(negedge clock);
         n++;
      end
      n = 0;
      while (chip_reset_req[1] === 1'b1 && n < 600) begin
         @(negedge clock);
         n++;
      end
      cmpi(n, `WIT_RST_CYCLES);
      rd(16'hffea, 8'h69);
      cmp1(interval_interrupt[1], 1'b0);
      $display("test reset pulse done");
      // Channel 1 interval overflow, then the NMI choice on the same channel.
      wr(16'hffea, 16'ha520);
      wr(16'hffea, 16'h5afe);
      n = 0;
      while (interval_interrupt[1] !== 1'b1 && n < 50) begin
         @(negedge clock);
         n++;
      end
      cmp1(interval_interrupt[1], 1'b1);
      cmp1(nmi_req[1] | chip_reset_req[1], 1'b0);
      wr(16'hffea, 16'ha561);
      wr(16'hffea, 16'h5afe);
      n = 0;
      while (nmi_req[1] !== 1'b1 && n < 300) begin
         @(negedge clock);
         n++;
      end
      cmp1(nmi_req[1], 1'b1);
      @(negedge clock);
      cmp1(nmi_req[1], 1'b0);
      $display("test channel 1 overflow done");
      test_done;
   end

   // Hang guard, sized well above the roughly 20500 cycles the tests need.
   initial begin
      repeat (60000) @(posedge clock);
      fail_count++;
      $display("wrong value at %0t: run did not finish", $time);
      test_done;
   end
endmodule
